// ### mdp_pkg.sv
// Package: offsets, field positions, reset values and widths of the main digital page.
package mdp_pkg;
	localparam logic [7:0] OFF_INTERLEAVE_RESET_CTRL   = 8'h00;
	localparam logic [7:0] OFF_INPUT_BAND_INDEX        = 8'h42;
	localparam logic [7:0] OFF_BAND_INDEX_ENABLE       = 8'h4E;
	localparam logic [7:0] OFF_OVERRANGE_FLAG_ENABLE   = 8'hAB;
	localparam logic [7:0] OFF_OVERRANGE_BIT_PLACEMENT = 8'hAD;
	localparam logic [7:0] OFF_DATAPATH_SOFT_RESET     = 8'hF7;
	localparam int         ENGINE_RESET_BIT            = 0;
	localparam int         BAND_EN_BIT                 = 7;
	localparam int         OVERRANGE_FLAG_ENABLE_BIT                  = 0;
	localparam int         DP_RESET_BIT                = 0;
	localparam int         BAND_W                      = 3;
	localparam int         PLACE_W                     = 4;
	localparam int         ILV_PAGE_DEPTH              = 16;
	localparam int         ILV_ADDR_W                  = 4;
	localparam logic [7:0] REG_RESET                   = 8'h00;
	localparam logic [7:0] ILV_DEFAULT                 = 8'h00;
	localparam logic [3:0] ILV_LAST_ADDR               = 4'hF;
endpackage

// ### ilv_page_mem.sv
// Interleaving configuration page storage with registered read data; the sweep clear is driven from the configuration page.
`timescale 1ns/1ps
module ilv_page_mem (
	input  wire logic       mclk_in,    // System clock.
	input  wire logic       rst_b_in,   // Synchronous reset, active low.
	input  wire logic       we_in,      // Write strobe.
	input  wire logic [3:0] waddr_in,   // Write address.
	input  wire logic [7:0] wdata_in,   // Write data.
	input  wire logic [3:0] raddr_in,   // Read address.
	output logic      [7:0] rdata_out   // Registered read data.
);
	logic [7:0] mem_q [mdp_pkg::ILV_PAGE_DEPTH];
	logic [7:0] rdata_q;

	always_ff @(posedge mclk_in) begin
		if (we_in) begin
			mem_q[waddr_in] <= wdata_in;
		end
		if (!rst_b_in) begin
			rdata_q <= mdp_pkg::REG_RESET;
		end else begin
			rdata_q <= mem_q[raddr_in];
		end
	end

	assign rdata_out = rdata_q;
endmodule // ilv_page_mem

// ### main_digital_config_page.sv
// Main digital configuration page: staged registers, engine reset pulse and overrange placement.
// Notes on behaviour
// - Engine reset bit is pulsed by software writing 1 then 0; never self-clears.
// - New page settings apply only after the engine reset bit's falling edge.
// - Engine reset pulse clears every interleaving page register to its default.
// - Three-bit band index k selects band k*fs/2 to (k+1)*fs/2.
// - Band enable at bit 7; 0 disables, 1 lets the index steer the engine.
// - Overrange enable at bit 0; 1 activates the placement field.
// - Placement 0011 flag on bit 0, 1100 bit 1, 1111 both, else noise; code flags bit 0 for 0111, 1011 and bit 1 for 1101, 1110.
// - Datapath reset bit resets digital block, then clears itself.
// - Datapath reset leaves interleaving correction state untouched.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
module main_digital_config_page (
	input  wire logic        mclk_in,        // 50 MHz system clock.
	input  wire logic        rst_b_in,       // Synchronous reset, active low.
	input  wire logic [7:0]  addr_in,        // Register address.
	input  wire logic [7:0]  wdata_in,       // Write data.
	input  wire logic        wr_in,          // Write strobe.
	input  wire logic        rd_in,          // Read strobe.
	input  wire logic        ilv_sel_in,     // 1 selects interleaving page window.
	input  wire logic [15:0] sample_in,      // Converter sample word.
	input  wire logic        ovr_flag_in,    // Overrange flag of this sample.
	output logic      [7:0]  rdata_out,      // Read data, cycle after strobe.
	output logic      [15:0] sample_out,     // Output word with flag placed.
	output logic             engine_rst_out, // Interleaving engine reset pulse.
	output logic             dp_rst_out,     // Datapath reset pulse.
	output logic      [2:0]  band_out,       // Applied band index.
	output logic             band_en_out     // Applied band selection enable.
);
	// ------------------------------------------------------------------
	// Staged (written) and applied register copies
	// ------------------------------------------------------------------
	// Software sees a write at once on readback; the engine sees it only after a commit.
	logic       eng_bit_q, eng_bit_d;
	logic [2:0] band_s_q, band_s_d, band_a_q, band_a_d;
	logic       bnen_s_q, bnen_s_d, bnen_a_q, bnen_a_d;
	logic       oven_s_q, oven_s_d, oven_a_q, oven_a_d;
	logic [3:0] plc_s_q, plc_s_d, plc_a_q, plc_a_d;
	logic       dp_q, dp_d;
	logic       eng_pulse_q, eng_pulse_d;
	logic [7:0] rdata_q, rdata_d;
	logic       ilv_rd_q, ilv_rd_d;
	logic       commit;
	logic [3:0] clr_addr_q, clr_addr_d;
	logic       clr_busy_q, clr_busy_d;

	// Main page address match; the interleaving window never hits a main page register.
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off, input logic sel);
		hit = !sel && (a == off);
	endfunction

	// Commit is the falling half of the pulse: a write of 0 while the bit holds 1.
	// Writing 1 alone only stages; the engine restarts when the bit drops again.
	assign commit = eng_bit_q && wr_in && hit(addr_in, mdp_pkg::OFF_INTERLEAVE_RESET_CTRL,
		ilv_sel_in) && !wdata_in[mdp_pkg::ENGINE_RESET_BIT];

	always_comb begin
		eng_bit_d   = eng_bit_q;
		band_s_d    = band_s_q;
		bnen_s_d    = bnen_s_q;
		oven_s_d    = oven_s_q;
		plc_s_d     = plc_s_q;
		dp_d        = 1'b0; // Self-clears one cycle after the write.
		eng_pulse_d = commit;
		if (wr_in && !ilv_sel_in) begin
			case (addr_in)
				mdp_pkg::OFF_INTERLEAVE_RESET_CTRL: begin
					eng_bit_d = wdata_in[mdp_pkg::ENGINE_RESET_BIT];
				end
				mdp_pkg::OFF_INPUT_BAND_INDEX: begin
					band_s_d = wdata_in[2:0];
				end
				mdp_pkg::OFF_BAND_INDEX_ENABLE: begin
					bnen_s_d = wdata_in[mdp_pkg::BAND_EN_BIT];
				end
				mdp_pkg::OFF_OVERRANGE_FLAG_ENABLE: begin
					oven_s_d = wdata_in[mdp_pkg::OVERRANGE_FLAG_ENABLE_BIT];
				end
				mdp_pkg::OFF_OVERRANGE_BIT_PLACEMENT: begin
					plc_s_d = wdata_in[3:0];
				end
				mdp_pkg::OFF_DATAPATH_SOFT_RESET: begin
					dp_d = wdata_in[mdp_pkg::DP_RESET_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	// Applied copies take the staged values only on the commit pulse.
	always_comb begin
		band_a_d = band_a_q;
		bnen_a_d = bnen_a_q;
		oven_a_d = oven_a_q;
		plc_a_d  = plc_a_q;
		if (commit) begin
			band_a_d = band_s_q;
			bnen_a_d = bnen_s_q;
			oven_a_d = oven_s_q;
			plc_a_d  = plc_s_q;
		end
	end

	// ------------------------------------------------------------------
	// Interleaving page: software window and sweep clear
	// ------------------------------------------------------------------
	// The clear sweeps one word per cycle; software writes during it are dropped.
	// A commit during a sweep restarts it from word zero.
	logic       mem_we;
	logic [3:0] mem_waddr;
	logic [7:0] mem_wdata;
	logic [7:0] mem_rdata;

	always_comb begin
		clr_busy_d = clr_busy_q;
		clr_addr_d = clr_addr_q;
		if (commit) begin
			clr_busy_d = 1'b1;
			clr_addr_d = 4'h0;
		end else if (clr_busy_q) begin
			clr_addr_d = clr_addr_q + 4'h1;
			if (clr_addr_q == mdp_pkg::ILV_LAST_ADDR) begin
				clr_busy_d = 1'b0;
			end
		end
		mem_we    = clr_busy_q || (wr_in && ilv_sel_in);
		mem_waddr = clr_busy_q ? clr_addr_q : addr_in[3:0];
		mem_wdata = clr_busy_q ? mdp_pkg::ILV_DEFAULT : wdata_in;
	end

	ilv_page_mem u_ilv (
		.mclk_in   (mclk_in),
		.rst_b_in  (rst_b_in),
		.we_in     (mem_we),
		.waddr_in  (mem_waddr),
		.wdata_in  (mem_wdata),
		.raddr_in  (addr_in[3:0]),
		.rdata_out (mem_rdata)
	);

	// ------------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------------
	// Main page reads show the staged copies, so software can check a setting before
	// it commits it. Unused bits always read as zero.
	always_comb begin
		rdata_d  = 8'h00;
		ilv_rd_d = rd_in && ilv_sel_in;
		if (rd_in && !ilv_sel_in) begin
			case (addr_in)
				mdp_pkg::OFF_INTERLEAVE_RESET_CTRL:   rdata_d = {7'h00, eng_bit_q};
				mdp_pkg::OFF_INPUT_BAND_INDEX:        rdata_d = {5'h00, band_s_q};
				mdp_pkg::OFF_BAND_INDEX_ENABLE:       rdata_d = {bnen_s_q, 7'h00};
				mdp_pkg::OFF_OVERRANGE_FLAG_ENABLE:   rdata_d = {7'h00, oven_s_q};
				mdp_pkg::OFF_OVERRANGE_BIT_PLACEMENT: rdata_d = {4'h0, plc_s_q};
				mdp_pkg::OFF_DATAPATH_SOFT_RESET:     rdata_d = {7'h00, dp_q};
				default:                              rdata_d = 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Overrange placement on the output word
	// ------------------------------------------------------------------
	logic [15:0] samp_d, samp_q;
	logic [1:0]  lane_on;

	// Each lane owns a pair of placement bits; a half-set pair leaves the sample bit alone.
	// An all-zero placement passes the converter's low bits, which then carry noise.
	for (genvar g = 0; g < 2; g++) begin : g_lane
		assign lane_on[g] = oven_a_q && (plc_a_q[2 * g + 1 -: 2] == 2'h3);
	end

	always_comb begin
		samp_d = sample_in;
		for (int b = 0; b < 2; b++) begin
			if (lane_on[b]) begin
				samp_d[b] = ovr_flag_in;
			end
		end
		if (dp_q) begin
			samp_d = 16'h0000; // Datapath reset flushes the word only.
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			eng_bit_q   <= 1'b0;
			band_s_q    <= 3'h0;
			bnen_s_q    <= 1'b0;
			oven_s_q    <= 1'b0;
			plc_s_q     <= 4'h0;
			band_a_q    <= 3'h0;
			bnen_a_q    <= 1'b0;
			oven_a_q    <= 1'b0;
			plc_a_q     <= 4'h0;
			dp_q        <= 1'b0;
			eng_pulse_q <= 1'b0;
			rdata_q     <= 8'h00;
			ilv_rd_q    <= 1'b0;
			clr_addr_q  <= 4'h0;
			clr_busy_q  <= 1'b0;
			samp_q      <= 16'h0000;
		end else begin
			eng_bit_q   <= eng_bit_d;
			band_s_q    <= band_s_d;
			bnen_s_q    <= bnen_s_d;
			oven_s_q    <= oven_s_d;
			plc_s_q     <= plc_s_d;
			band_a_q    <= band_a_d;
			bnen_a_q    <= bnen_a_d;
			oven_a_q    <= oven_a_d;
			plc_a_q     <= plc_a_d;
			dp_q        <= dp_d;
			eng_pulse_q <= eng_pulse_d;
			rdata_q     <= rdata_d;
			ilv_rd_q    <= ilv_rd_d;
			clr_addr_q  <= clr_addr_d;
			clr_busy_q  <= clr_busy_d;
			samp_q      <= samp_d;
		end
	end

	// The memory read register is muxed after the flop; both sources are registered.
	// A further output register would cost a cycle of read latency that the bus cannot give.
	assign rdata_out      = ilv_rd_q ? mem_rdata : rdata_q;
	assign sample_out     = samp_q;
	assign engine_rst_out = eng_pulse_q;
	assign dp_rst_out     = dp_q;
	assign band_out       = band_a_q;
	assign band_en_out    = bnen_a_q;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	chk_commit_pulse: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		commit |=> engine_rst_out ##1 !engine_rst_out)
		else $error("engine reset pulse missing");
	chk_pulse_source: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		engine_rst_out |-> $past(commit))
		else $error("engine reset pulse without a commit");
	chk_engine_bit_sticky: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		eng_bit_q && !(wr_in && !ilv_sel_in && addr_in == 8'h00) |=> eng_bit_q)
		else $error("engine reset bit cleared itself");

	chk_hold_applied: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		!commit |=> $stable(band_a_q) && $stable(plc_a_q) && $stable(oven_a_q)
		&& $stable(bnen_a_q))
		else $error("setting applied without pulse");
	chk_apply_on_pulse: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		commit |=> band_out == $past(band_s_q) && band_en_out == $past(bnen_s_q))
		else $error("setting not applied on pulse");
	chk_ovr_apply: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		commit |=> oven_a_q == $past(oven_s_q) && plc_a_q == $past(plc_s_q))
		else $error("overrange setting not applied on pulse");

	chk_clear_start: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		commit |=> clr_busy_q && clr_addr_q == 4'h0)
		else $error("interleaving page clear did not start");
	chk_clear_step: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		clr_busy_q && !commit && clr_addr_q != mdp_pkg::ILV_LAST_ADDR
		|=> clr_busy_q && clr_addr_q == $past(clr_addr_q) + 4'h1)
		else $error("interleaving page clear skipped a word");
	chk_clear_sweep: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		clr_busy_q && !commit && clr_addr_q == mdp_pkg::ILV_LAST_ADDR |=> !clr_busy_q)
		else $error("interleaving page clear wrong length");

	chk_flag_bit0: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		oven_a_q && plc_a_q[1:0] == 2'h3 && !dp_q |=> sample_out[0] == $past(ovr_flag_in))
		else $error("flag not on bit 0");
	chk_flag_bit1: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		oven_a_q && plc_a_q[3:2] == 2'h3 && !dp_q |=> sample_out[1] == $past(ovr_flag_in))
		else $error("flag not on bit 1");
	chk_flag_off: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		!oven_a_q && !dp_q |=> sample_out == $past(sample_in))
		else $error("word altered while overrange disabled");

	chk_dp_self_clear: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		dp_rst_out && !(wr_in && !ilv_sel_in && addr_in == mdp_pkg::OFF_DATAPATH_SOFT_RESET)
		|=> !dp_rst_out)
		else $error("datapath reset did not clear");
	chk_dp_flush: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		dp_q |=> sample_out == 16'h0000)
		else $error("datapath reset did not flush the word");
	chk_dp_keeps_ilv: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		dp_q && !commit |=> $stable(band_a_q) && !engine_rst_out)
		else $error("datapath reset touched interleaving");

	chk_unused_zero: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		rd_in && !ilv_sel_in && addr_in == mdp_pkg::OFF_INPUT_BAND_INDEX
		|=> rdata_out[7:3] == 5'h00)
		else $error("unused band index bits read back");

	// ------------------------------------------------------------------
	// Cover points
	// ------------------------------------------------------------------
	cov_commit: cover property (@(posedge mclk_in) commit);
	cov_dp: cover property (@(posedge mclk_in) dp_rst_out);
	cov_both_bits: cover property (@(posedge mclk_in) oven_a_q && plc_a_q == 4'hF);
	cov_band_enabled: cover property (@(posedge mclk_in) commit && bnen_s_q);
	cov_ilv_read: cover property (@(posedge mclk_in) ilv_rd_q && !clr_busy_q);
endmodule // main_digital_config_page

// ### testbench.sv
// Self-checking testbench for the main digital configuration page.
`timescale 1ns/1ps
module testbench;
	logic        mclk_in = 1'b0;
	logic        rst_b_in = 1'b0;
	logic [7:0]  addr_in = 8'h00;
	logic [7:0]  wdata_in = 8'h00;
	logic        wr_in = 1'b0;
	logic        rd_in = 1'b0;
	logic        ilv_sel_in = 1'b0;
	logic [15:0] sample_in = 16'h0000;
	logic        ovr_flag_in = 1'b0;
	logic [7:0]  rdata_out;
	logic [15:0] sample_out;
	logic        engine_rst_out;
	logic        dp_rst_out;
	logic [2:0]  band_out;
	logic        band_en_out;
	int          n_errors = 0;
	int          tests_run = 0;
	logic [2:0]  pb = 3'h0;
	logic        pe = 1'b0;
	logic        oe = 1'b0;
	logic [3:0]  op = 4'h0;
	logic [3:0]  app = 4'h0;
	logic [7:0]  d;
	logic [15:0] s;
	logic        f;
	logic [7:0]  offs [6] = '{8'h00, 8'h42, 8'h4E, 8'hAB, 8'hAD, 8'hF7};
	logic [3:0]  pls [4] = '{4'h0, 4'h3, 4'hC, 4'hF};

	main_digital_config_page dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .ilv_sel_in(ilv_sel_in),
		.sample_in(sample_in), .ovr_flag_in(ovr_flag_in), .rdata_out(rdata_out),
		.sample_out(sample_out), .engine_rst_out(engine_rst_out), .dp_rst_out(dp_rst_out),
		.band_out(band_out), .band_en_out(band_en_out));

	initial begin
		forever #10 mclk_in = ~mclk_in;
	end

	// ---------------------------------------------------------------
	// Comparison and bus tasks
	// ---------------------------------------------------------------
	task automatic tally(input logic ok, input string what);
		tests_run++;
		if (!ok) begin
			n_errors++;
			$display("BAD %0t %s", $time, what);
		end
	endtask
	task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
		tally(got === exp, $sformatf("read got %h exp %h", got, exp));
	endtask
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		tally(got === exp, $sformatf("word got %h exp %h", got, exp));
	endtask
	task automatic chk_ctl(input logic [3:0] got, input logic [3:0] exp);
		tally(got === exp, $sformatf("control got %h exp %h", got, exp));
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic sel = 1'b0);
		@(posedge mclk_in);
		addr_in <= a;
		wdata_in <= v;
		ilv_sel_in <= sel;
		wr_in <= 1'b1;
		@(posedge mclk_in);
		wr_in <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe, so they are sampled there.
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic sel = 1'b0);
		@(posedge mclk_in);
		addr_in <= a;
		ilv_sel_in <= sel;
		rd_in <= 1'b1;
		@(posedge mclk_in);
		rd_in <= 1'b0;
		@(negedge mclk_in);
		chk_rd(rdata_out, exp);
	endtask

	task automatic commit();
		wr(8'h00, 8'h01);
		rd(8'h00, 8'h01);
		chk_ctl({3'h0, engine_rst_out}, 4'h0);
		chk_ctl({band_en_out, band_out}, app);
		wr(8'h00, 8'h00);
		@(negedge mclk_in);
		chk_ctl({3'h0, engine_rst_out}, 4'h1);
		chk_ctl({1'b0, band_out}, {1'b0, pb});
		chk_ctl({3'h0, band_en_out}, {3'h0, pe});
		@(negedge mclk_in);
		chk_ctl({3'h0, engine_rst_out}, 4'h0);
		app = {pe, pb};
		// Let the page clear finish, since interleaving writes during it are dropped.
		repeat (16) @(posedge mclk_in);
	endtask

	function automatic logic [15:0] exp_word(input logic [15:0] w, input logic fl);
		exp_word = w;
		if (oe && op[1:0] == 2'b11) exp_word[0] = fl;
		if (oe && op[3:2] == 2'b11) exp_word[1] = fl;
	endfunction

	task automatic samp(input logic [15:0] w, input logic fl);
		@(posedge mclk_in);
		sample_in <= w;
		ovr_flag_in <= fl;
		@(posedge mclk_in);
		@(negedge mclk_in);
		// Low bits are noise while enabled with an all-zero placement, so they are masked.
		if (oe && op == 4'h0)
			chk_word(sample_out & 16'hFFFC, w & 16'hFFFC);
		else
			chk_word(sample_out, exp_word(w, fl));
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		void'($urandom(31));
		repeat (10) @(posedge mclk_in);
		rst_b_in <= 1'b1;
		foreach (offs[i]) rd(offs[i], 8'h00);
		wr(8'h10, 8'hFF);
		rd(8'h10, 8'h00);
		for (int k = 0; k < 8; k++) begin
			d = 8'($urandom);
			wr(8'h42, {d[7:3], 3'(k)});
			rd(8'h42, {5'h00, 3'(k)});
			wr(8'h4E, {d[0], d[7:1]});
			rd(8'h4E, {d[0], 7'h00});
			pb = 3'(k);
			pe = d[0];
			commit();
		end
		d = 8'($urandom);
		wr(8'h05, d, 1'b1);
		rd(8'h05, d, 1'b1);
		wr(8'hF7, 8'h01);
		@(negedge mclk_in);
		chk_ctl({2'h0, dp_rst_out, engine_rst_out}, 4'h2);
		@(negedge mclk_in);
		chk_ctl({3'h0, dp_rst_out}, 4'h0);
		chk_ctl({band_en_out, band_out}, {pe, pb});
		rd(8'hF7, 8'h00);
		rd(8'h05, d, 1'b1);
		commit();
		repeat (18) @(posedge mclk_in);
		rd(8'h05, 8'h00, 1'b1);
		for (int i = 0; i < 8; i++) begin
			wr(8'hAB, {7'h00, i[0]});
			wr(8'hAD, {4'h0, pls[i / 2]});
			samp(16'h0000, 1'b1);
			oe = i[0];
			op = pls[i / 2];
			commit();
			samp(16'h0000, 1'b1);
			samp(16'hFFFF, 1'b0);
			repeat (4) begin
				s = 16'($urandom);
				f = 1'($urandom);
				samp(s, f);
			end
		end
		final_report();
	end

	initial begin
		#(20 * 20000);
		n_errors++;
		final_report();
	end
endmodule // testbench
